// ==== src/ppcs_top.sv ====
// Chip-select cycle timing engine and slave-mode byte buffers with status flags.
`timescale 1ns/10ps
`default_nettype none
`include "ppcs_params.svh"
module ppcs_top
	import ppcs_pkg::*;
(
	CLK_SYS,
	RST_N,
	CE,
	REG_ADDR,
	REG_WDATA,
	REG_WR,
	REG_RD,
	REG_RDATA,
	IRQ,
	CYC_REQ,
	CYC_WRITE,
	CYC_BUSY,
	CYC_DONE,
	CYC_TIMEOUT,
	STROBE,
	DATA_DRIVE,
	EXT_ACK,
	SLV_WR,
	SLV_RD,
	SLV_ADDR,
	SLV_WDATA,
	SLV_RDATA,
	INPUT_BUFFER_TYPE_SELECT
);
	input wire logic CLK_SYS;
	input wire logic RST_N;
	input wire logic CE;
	input wire logic [2:0] REG_ADDR;
	input wire logic [15:0] REG_WDATA;
	input wire logic REG_WR;
	input wire logic REG_RD;
	output logic [15:0] REG_RDATA;
	output logic IRQ;
	input wire logic CYC_REQ;
	input wire logic CYC_WRITE;
	output logic CYC_BUSY;
	output logic CYC_DONE;
	output logic CYC_TIMEOUT;
	output logic STROBE;
	output logic DATA_DRIVE;
	input wire logic EXT_ACK;
	input wire logic SLV_WR;
	input wire logic SLV_RD;
	input wire logic [1:0] SLV_ADDR;
	input wire logic [7:0] SLV_WDATA;
	output logic [7:0] SLV_RDATA;
	output logic INPUT_BUFFER_TYPE_SELECT;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] ack_sync_q, wr_sync_q, rd_sync_q;
	logic ack_q, wr_lvl_q, rd_lvl_q;
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ack_sync_q <= 3'h0;
			wr_sync_q <= 3'h0;
			rd_sync_q <= 3'h0;
			ack_q <= 1'b0;
			wr_lvl_q <= 1'b0;
			rd_lvl_q <= 1'b0;
		end else if (CE) begin
			ack_sync_q <= {ack_sync_q[1:0], EXT_ACK};
			wr_sync_q <= {wr_sync_q[1:0], SLV_WR};
			rd_sync_q <= {rd_sync_q[1:0], SLV_RD};
			if (ack_sync_q[1] == ack_sync_q[2])
				ack_q <= ack_sync_q[2];
			if (wr_sync_q[1] == wr_sync_q[2])
				wr_lvl_q <= wr_sync_q[2];
			if (rd_sync_q[1] == rd_sync_q[2])
				rd_lvl_q <= rd_sync_q[2];
		end
	end
	logic wr_agree, rd_agree, slv_wr_ev, slv_rd_ev;
	assign wr_agree = (wr_sync_q[1] == wr_sync_q[2]) ? wr_sync_q[2] : wr_lvl_q;
	assign rd_agree = (rd_sync_q[1] == rd_sync_q[2]) ? rd_sync_q[2] : rd_lvl_q;
	assign slv_wr_ev = CE && wr_agree && !wr_lvl_q;
	assign slv_rd_ev = CE && rd_agree && !rd_lvl_q;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0] mode_q;
	logic pad_q, slave_en_q;
	logic [1:0] irq_st_q, irq_msk_q;
	logic [7:0] ibuf_q [0:3];
	logic [7:0] output_underflow_q [0:3];
	logic [3:0] ib_full_q, ob_empty_q;
	logic ib_ov_q, ob_uf_q;
	logic [1:0] cpu_ib_idx, cpu_ob_idx;
	logic [1:0] slv_idx;
	logic reg_wr, reg_rd;
	assign reg_wr = CE && REG_WR;
	assign reg_rd = CE && REG_RD;
	assign cpu_ib_idx = REG_WDATA[9:8];
	assign cpu_ob_idx = REG_WDATA[9:8];
	assign slv_idx = SLV_ADDR;

	// Word-pair mask: a CPU byte access touches both bytes of its pair.
	function automatic logic [3:0] pair_mask(input logic [1:0] idx);
		pair_mask = idx[1] ? 4'hC : 4'h3;
	endfunction

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			mode_q <= 16'h0000;
			pad_q <= 1'b0;
			slave_en_q <= 1'b0;
			irq_msk_q <= 2'h0;
		end else if (reg_wr) begin
			unique case (REG_ADDR)
				`PPCS_REG_MODE: mode_q <= REG_WDATA & `PPCS_MODE_MASK;
				`PPCS_REG_PAD: pad_q <= REG_WDATA[0];
				`PPCS_REG_CTRL: slave_en_q <= REG_WDATA[0];
				`PPCS_REG_IRQ_MSK: irq_msk_q <= REG_WDATA[1:0];
				default: ;
			endcase
		end
	end
	assign INPUT_BUFFER_TYPE_SELECT = pad_q;

	// CPU reads an input byte selected by the index latched from the previous IBUF write of an index.
	logic [1:0] rd_sel_q;
	logic cpu_ib_rd, cpu_ob_wr, ext_wr, ext_rd;
	assign cpu_ib_rd = reg_rd && REG_ADDR == `PPCS_REG_IBUF && slave_en_q;
	assign cpu_ob_wr = reg_wr && REG_ADDR == `PPCS_REG_OUTPUT_UNDERFLOW && slave_en_q;
	assign ext_wr = slv_wr_ev && slave_en_q;
	assign ext_rd = slv_rd_ev && slave_en_q;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N)
			rd_sel_q <= 2'h0;
		else if (reg_wr && REG_ADDR == `PPCS_REG_IBUF)
			rd_sel_q <= cpu_ib_idx;
	end

	// Input buffers, filled from the external master.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ib_full_q <= 4'h0;
			for (int i = 0; i < 4; i++)
				ibuf_q[i] <= 8'h00;
		end else begin
			if (cpu_ib_rd)
				ib_full_q <= ib_full_q & ~pair_mask(rd_sel_q);
			if (ext_wr && !ib_full_q[slv_idx]) begin
				ibuf_q[slv_idx] <= SLV_WDATA;
				ib_full_q[slv_idx] <= 1'b1;
			end
		end
	end

	// Output buffers, drained by the external master.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ob_empty_q <= 4'hF;
			SLV_RDATA <= 8'h00;
			for (int i = 0; i < 4; i++)
				output_underflow_q[i] <= 8'h00;
		end else begin
			if (cpu_ob_wr) begin
				output_underflow_q[cpu_ob_idx] <= REG_WDATA[7:0];
				ob_empty_q <= ob_empty_q & ~pair_mask(cpu_ob_idx);
			end
			if (ext_rd) begin
				SLV_RDATA <= output_underflow_q[slv_idx];
				ob_empty_q[slv_idx] <= 1'b1;
			end
		end
	end

	// Sticky error flags: hardware set wins over a software clear.
	logic stat_wr;
	assign stat_wr = reg_wr && REG_ADDR == `PPCS_REG_STAT;
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ib_ov_q <= 1'b0;
			ob_uf_q <= 1'b0;
		end else begin
			if (ext_wr && ib_full_q[slv_idx])
				ib_ov_q <= 1'b1;
			else if (stat_wr && !REG_WDATA[14])
				ib_ov_q <= 1'b0;
			if (ext_rd && ob_empty_q[slv_idx])
				ob_uf_q <= 1'b1;
			else if (stat_wr && !REG_WDATA[6])
				ob_uf_q <= 1'b0;
		end
	end

	logic in_all_full, out_all_empty;
	assign in_all_full = &ib_full_q;
	assign out_all_empty = &ob_empty_q;
	logic [15:0] stat_word;
	assign stat_word = {in_all_full, ib_ov_q, 2'b00, ib_full_q, out_all_empty, ob_uf_q, 2'b00, ob_empty_q};

	// ----------------------------------------------------------------
	// Chip-select cycle engine
	// ----------------------------------------------------------------
	ppcs_state_type state_q;
	logic [1:0] phase_q;
	logic [5:0] cnt_q;
	logic [7:0] tmo_q;
	logic tmo_en_q, is_wr_q;
	ppcs_ack_type ack_mode;
	logic [1:0] setup_wait, hold_wait;
	logic [3:0] strobe_wait;
	assign ack_mode = ppcs_ack_type'(mode_q[`PPCS_ACK_HI:`PPCS_ACK_LO]);
	assign setup_wait = mode_q[`PPCS_SETUP_HI:`PPCS_SETUP_LO];
	assign strobe_wait = mode_q[`PPCS_STROBE_HI:`PPCS_STROBE_LO];
	assign hold_wait = mode_q[`PPCS_HOLD_HI:`PPCS_HOLD_LO];

	// Timing is kept in quarter cycles; one clock stands for one quarter.
	logic ack_end, tmo_end, strobe_end;
	assign ack_end = (ack_mode == PPCS_ACK_WAIT || ack_mode == PPCS_ACK_TIMEOUT) && ack_q;
	assign tmo_end = tmo_en_q && tmo_q == 8'h00;
	// Acknowledge modes still keep the programmed minimum strobe before an end is taken.
	assign strobe_end = (ack_mode == PPCS_ACK_NONE || ack_mode == PPCS_ACK_RSVD) ? cnt_q == 6'h00
		: (cnt_q == 6'h00 && (ack_end || tmo_end));

	logic [6:0] load_strobe;
	assign load_strobe = {1'b0, strobe_wait, 2'b00} + (CYC_WRITE ? 7'h01 : 7'h02);
	logic [7:0] tmo_load;
	assign tmo_load = (strobe_wait == 4'h0) ? `PPCS_ACK_TIMEOUT_MAX : {4'h0, strobe_wait};

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state_q <= PPCS_IDLE;
			phase_q <= 2'h0;
			cnt_q <= 6'h00;
			tmo_q <= 8'h00;
			tmo_en_q <= 1'b0;
			is_wr_q <= 1'b0;
			CYC_DONE <= 1'b0;
			CYC_TIMEOUT <= 1'b0;
		end else if (CE) begin
			phase_q <= phase_q + 2'h1;
			CYC_DONE <= 1'b0;
			unique case (state_q)
				PPCS_IDLE: if (CYC_REQ) begin
					is_wr_q <= CYC_WRITE;
					cnt_q <= {2'b00, setup_wait, 2'b00};
					state_q <= PPCS_SETUP;
				end
				PPCS_SETUP: if (cnt_q == 6'h00) begin
					cnt_q <= load_strobe[5:0];
					tmo_q <= tmo_load;
					tmo_en_q <= ack_mode == PPCS_ACK_TIMEOUT;
					CYC_TIMEOUT <= 1'b0;
					state_q <= PPCS_STROBE;
				end else
					cnt_q <= cnt_q - 6'h01;
				PPCS_STROBE: begin
					if (cnt_q != 6'h00)
						cnt_q <= cnt_q - 6'h01;
					if (phase_q == 2'h3 && tmo_q != 8'h00)
						tmo_q <= tmo_q - 8'h01;
					if (strobe_end) begin
						CYC_TIMEOUT <= tmo_end && !ack_end;
						cnt_q <= is_wr_q ? {2'b00, hold_wait, 2'b00}
							: {2'b00, hold_wait, 2'b00} - 6'h01;
						state_q <= (!is_wr_q && hold_wait == 2'h0) ? PPCS_IDLE : PPCS_HOLD;
						CYC_DONE <= !is_wr_q && hold_wait == 2'h0;
					end
				end
				PPCS_HOLD: if (cnt_q == 6'h00 || (!is_wr_q && cnt_q[5:2] == 4'h0 && cnt_q[1:0] == 2'h0)) begin
					CYC_DONE <= 1'b1;
					state_q <= PPCS_IDLE;
				end else
					cnt_q <= cnt_q - 6'h01;
			endcase
		end
	end
	assign CYC_BUSY = state_q != PPCS_IDLE;
	assign STROBE = state_q == PPCS_STROBE;
	assign DATA_DRIVE = is_wr_q && state_q != PPCS_IDLE;

	// ----------------------------------------------------------------
	// Interrupts and read-back
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N)
			irq_st_q <= 2'h0;
		else if (CE) begin
			for (int i = 0; i < 2; i++) begin
				if ((i == 0 && CYC_DONE) || (i == 1 && ((ext_wr && ib_full_q[slv_idx]) || (ext_rd && ob_empty_q[slv_idx]))))
					irq_st_q[i] <= 1'b1;
				else if (reg_wr && REG_ADDR == `PPCS_REG_IRQ_ST && REG_WDATA[i])
					irq_st_q[i] <= 1'b0;
			end
		end
	end
	assign IRQ = |(irq_st_q & irq_msk_q);

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N)
			REG_RDATA <= 16'h0000;
		else if (reg_rd) begin
			unique case (REG_ADDR)
				`PPCS_REG_MODE: REG_RDATA <= mode_q;
				`PPCS_REG_STAT: REG_RDATA <= slave_en_q ? stat_word : `PPCS_STAT_RESET;
				`PPCS_REG_PAD: REG_RDATA <= {15'h0000, pad_q};
				`PPCS_REG_IBUF: REG_RDATA <= {6'h00, rd_sel_q, ibuf_q[rd_sel_q]};
				`PPCS_REG_OUTPUT_UNDERFLOW: REG_RDATA <= {12'h000, ob_empty_q};
				`PPCS_REG_CTRL: REG_RDATA <= {13'h0000, CYC_TIMEOUT, CYC_BUSY, slave_en_q};
				`PPCS_REG_IRQ_ST: REG_RDATA <= {14'h0000, irq_st_q};
				`PPCS_REG_IRQ_MSK: REG_RDATA <= {14'h0000, irq_msk_q};
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== src/ppcs_params.svh ====
// Constants for the parallel port chip-select timing and slave buffer status block.
`ifndef PPCS_PARAMS_SVH
`define PPCS_PARAMS_SVH
`define PPCS_REG_MODE 3'h0
`define PPCS_REG_STAT 3'h1
`define PPCS_REG_PAD 3'h2
`define PPCS_REG_IBUF 3'h3
`define PPCS_REG_OUTPUT_UNDERFLOW 3'h4
`define PPCS_REG_CTRL 3'h5
`define PPCS_REG_IRQ_ST 3'h6
`define PPCS_REG_IRQ_MSK 3'h7
`define PPCS_ACK_HI 15
`define PPCS_ACK_LO 14
`define PPCS_SETUP_HI 7
`define PPCS_SETUP_LO 6
`define PPCS_STROBE_HI 5
`define PPCS_STROBE_LO 2
`define PPCS_HOLD_HI 1
`define PPCS_HOLD_LO 0
`define PPCS_MODE_MASK 16'hC0FF
`define PPCS_STAT_RESET 16'h008F
`define PPCS_ACK_TIMEOUT_MAX 8'hFF
`define PPCS_TCY_NS 20
`define PPCS_QUARTERS_PER_TCY 3'h4
`endif

// ==== src/ppcs_pkg.sv ====
// Types for the parallel port chip-select timing and slave buffer status block.
package ppcs_pkg;
	typedef enum logic [1:0] {PPCS_ACK_NONE, PPCS_ACK_TIMEOUT, PPCS_ACK_WAIT, PPCS_ACK_RSVD} ppcs_ack_type;
	typedef enum {PPCS_IDLE, PPCS_SETUP, PPCS_STROBE, PPCS_HOLD} ppcs_state_type;
endpackage

// ==== testbench/ppcs_top_chk.sv ====
// Assertions on the cycle engine timing and the register read port.
`timescale 1ns/10ps
`default_nettype none
module ppcs_top_chk (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic REG_RD,
	input wire logic [15:0] REG_RDATA,
	input wire logic CYC_REQ,
	input wire logic CYC_BUSY,
	input wire logic CYC_DONE,
	input wire logic CYC_TIMEOUT,
	input wire logic STROBE,
	input wire logic DATA_DRIVE
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	AST_START_ON_REQ: assert property ($rose(CYC_BUSY) |-> $past(CYC_REQ)) else $error("cycle began unasked");
	AST_STROBE_IN_CYCLE: assert property (STROBE |-> CYC_BUSY) else $error("strobe outside a cycle");
	AST_SETUP_FIRST: assert property ($rose(STROBE) |-> $past(CYC_BUSY) && !$past(STROBE))
		else $error("strobe without set-up");
	AST_WR_DATA_SETUP: assert property ($rose(STROBE) && DATA_DRIVE |-> $past(DATA_DRIVE))
		else $error("write data late");
	AST_WR_STROBE_MIN: assert property ($rose(STROBE) && DATA_DRIVE |-> STROBE[*2])
		else $error("write strobe short");
	AST_RD_STROBE_MIN: assert property ($rose(STROBE) && !DATA_DRIVE |-> STROBE[*3])
		else $error("read strobe short");
	AST_WR_HOLD: assert property ($fell(STROBE) && $past(DATA_DRIVE) |-> DATA_DRIVE && CYC_BUSY)
		else $error("write hold missing");
	AST_DONE_AT_END: assert property ($fell(CYC_BUSY) |-> ##[0:1] CYC_DONE) else $error("no done pulse");
	AST_DONE_PULSE: assert property (CYC_DONE |=> !CYC_DONE) else $error("done too long");
	AST_TMO_AT_DONE: assert property ($rose(CYC_TIMEOUT) |-> CYC_DONE) else $error("time-out off end");
	AST_RDATA_HOLD: assert property (!$past(REG_RD) |-> $stable(REG_RDATA)) else $error("read data moved");
endmodule
`default_nettype wire

// ==== testbench/ppcs_ext_master.sv ====
// Behavioural external master driving the slave buffer pins and the acknowledge.
`timescale 1ns/10ps
`default_nettype none
module ppcs_ext_master (
	input wire logic CLK_SYS,
	input wire logic STROBE,
	input wire logic [7:0] SLV_RDATA,
	output logic EXT_ACK = 1'h0,
	output logic SLV_WR = 1'h0,
	output logic SLV_RD = 1'h0,
	output logic [1:0] SLV_ADDR = 2'h0,
	output logic [7:0] SLV_WDATA = 8'hA5
);
	int ack_dly = -1;
	int n = 0;
	// A negative delay leaves the acknowledge low for good.
	always @(posedge CLK_SYS) begin
		n <= STROBE ? n + 1 : 0;
		EXT_ACK <= STROBE && ack_dly >= 0 && n >= ack_dly;
	end
	task automatic acc(input logic wr, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge CLK_SYS);
		SLV_ADDR <= a;
		SLV_WDATA <= d;
		@(posedge CLK_SYS);
		SLV_WR <= wr;
		SLV_RD <= !wr;
		repeat (8) @(posedge CLK_SYS);
		q = SLV_RDATA;
		SLV_WR <= 1'h0;
		SLV_RD <= 1'h0;
		repeat (2) @(posedge CLK_SYS);
		SLV_WDATA <= ~d;
		repeat (6) @(posedge CLK_SYS);
	endtask
endmodule
`default_nettype wire

// ==== testbench/test_ppcs_top.sv ====
// Self-checking bench for the cycle timing engine and the slave buffer status.
`timescale 1ns/10ps
`default_nettype none
`include "ppcs_params.svh"
module test_ppcs_top;
	logic clk_sys = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, cyc_req = 1'h0, cyc_write = 1'h0;
	logic [2:0] reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, v, md;
	logic irq, busy, done, tmo, strobe, drive, ack, swr, srd, ibts;
	logic [1:0] saddr;
	logic [7:0] swdata, srdata, q;
	logic [15:0] modes [4] = '{16'h0000, 16'h00FF, 16'h0045, 16'hC086};
	int n_errors = 0, num_checks = 0, s, m, h, i, w;
	ppcs_top ppcs_top_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(1'h1), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq),
		.CYC_REQ(cyc_req), .CYC_WRITE(cyc_write), .CYC_BUSY(busy), .CYC_DONE(done), .CYC_TIMEOUT(tmo),
		.STROBE(strobe), .DATA_DRIVE(drive), .EXT_ACK(ack), .SLV_WR(swr), .SLV_RD(srd), .SLV_ADDR(saddr),
		.SLV_WDATA(swdata), .SLV_RDATA(srdata), .INPUT_BUFFER_TYPE_SELECT(ibts));
	ppcs_ext_master ppcs_ext_master_inst (.CLK_SYS(clk_sys), .STROBE(strobe), .SLV_RDATA(srdata),
		.EXT_ACK(ack), .SLV_WR(swr), .SLV_RD(srd), .SLV_ADDR(saddr), .SLV_WDATA(swdata));
	always #10 clk_sys = ~clk_sys;
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	task automatic rc(input string nm, input logic [2:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(nm, d, e);
	endtask
	// Counts set-up, strobe and hold clocks of one cycle, sampled mid-cycle.
	task automatic cyc(input logic wn);
		int k;
		s = 0;
		m = 0;
		h = 0;
		@(posedge clk_sys);
		cyc_req <= 1'h1;
		cyc_write <= wn;
		@(posedge clk_sys);
		cyc_req <= 1'h0;
		for (k = 0; k < 3000 && !done; k++) begin
			@(negedge clk_sys);
			if (strobe) m++;
			else if (busy && m == 0) s++;
			else if (busy) h++;
		end
		if (k == 3000) begin
			chk("cycle end", 16'h0000, 16'h0001);
			end_sim();
		end
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'h1;
		rc("mode reset", `PPCS_REG_MODE, 16'h0000);
		rc("status reset", `PPCS_REG_STAT, 16'h008F);
		rc("pad reset", `PPCS_REG_PAD, 16'h0000);
		wr(`PPCS_REG_MODE, 16'hFFFF);
		rc("mode bits", `PPCS_REG_MODE, 16'hC0FF);
		foreach (modes[j]) for (w = 0; w < 2; w++) begin
			md = modes[j];
			wr(`PPCS_REG_MODE, md);
			cyc(w[0]);
			chk("setup", 16'(s), 16'(4 * md[7:6] + 1));
			chk("strobe", 16'(m), 16'(4 * md[5:2] + 2 + (w == 0)));
			chk("hold", 16'(h), 16'(4 * md[1:0] + w));
		end
		chk("irq masked", 16'(irq), 16'h0000);
		wr(`PPCS_REG_IRQ_MSK, 16'h0001);
		chk("irq done", 16'(irq), 16'h0001);
		wr(`PPCS_REG_IRQ_ST, 16'h0001);
		rc("irq cleared", `PPCS_REG_IRQ_ST, 16'h0000);
		ppcs_ext_master_inst.ack_dly = 10;
		wr(`PPCS_REG_MODE, 16'h8000);
		cyc(1'h0);
		chk("ack wait", 16'(m >= 10), 16'h0001);
		chk("ack no tmo", 16'(tmo), 16'h0000);
		ppcs_ext_master_inst.ack_dly = 0;
		wr(`PPCS_REG_MODE, 16'h4000);
		cyc(1'h0);
		chk("ack early", 16'(tmo == 1'h0 && m < 20), 16'h0001);
		ppcs_ext_master_inst.ack_dly = -1;
		wr(`PPCS_REG_MODE, 16'h4004);
		cyc(1'h0);
		chk("tmo", 16'(tmo), 16'h0001);
		ppcs_ext_master_inst.acc(1'h1, 2'h0, 8'h77, q);
		rc("slave off", `PPCS_REG_STAT, 16'h008F);
		wr(`PPCS_REG_CTRL, 16'h0001);
		wr(`PPCS_REG_IRQ_MSK, 16'h0002);
		for (i = 0; i < 4; i++) begin
			ppcs_ext_master_inst.acc(1'h1, i[1:0], 8'(8'h10 + i), q);
			rc("in full", `PPCS_REG_STAT, i < 3 ? 16'(16'h008F | (16'h0100 << (i + 1)) - 16'h0100) : 16'h8F8F);
		end
		ppcs_ext_master_inst.acc(1'h1, 2'h0, 8'h99, q);
		rc("overflow", `PPCS_REG_STAT, 16'hCF8F);
		chk("irq err", 16'(irq), 16'h0001);
		wr(`PPCS_REG_IBUF, 16'h0100);
		rc("in byte", `PPCS_REG_IBUF, 16'h0111);
		rc("in pair", `PPCS_REG_STAT, 16'h4C8F);
		wr(`PPCS_REG_STAT, 16'h0000);
		rc("ovf clear", `PPCS_REG_STAT, 16'h0C8F);
		wr(`PPCS_REG_IRQ_ST, 16'h0002);
		chk("irq clear", 16'(irq), 16'h0000);
		wr(`PPCS_REG_OUTPUT_UNDERFLOW, 16'h025A);
		rc("out pair", `PPCS_REG_STAT, 16'h0C03);
		ppcs_ext_master_inst.acc(1'h0, 2'h2, 8'h00, q);
		chk("out byte", {8'h00, q}, 16'h005A);
		rd(`PPCS_REG_STAT, v);
		chk("out taken", 16'(v[2]), 16'h0001);
		ppcs_ext_master_inst.acc(1'h0, 2'h0, 8'h00, q);
		rd(`PPCS_REG_STAT, v);
		chk("underflow", 16'(v[6]), 16'h0001);
		wr(`PPCS_REG_PAD, 16'h0001);
		rc("pad", `PPCS_REG_PAD, 16'h0001);
		chk("pad pin", 16'(ibts), 16'h0001);
		end_sim();
	end
endmodule
bind ppcs_top ppcs_top_chk ppcs_top_chk_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .CYC_REQ(CYC_REQ), .CYC_BUSY(CYC_BUSY), .CYC_DONE(CYC_DONE),
	.CYC_TIMEOUT(CYC_TIMEOUT), .STROBE(STROBE), .DATA_DRIVE(DATA_DRIVE));
`default_nettype wire
